/* File: rtl/bit_shift_flag_execute.sv */
// Overview of operation
// (RULE_01) push stores the source register on the stack and pop loads the destination from it.
// (RULE_02) io bit set forces bit b of I/O register P to one, io bit clear to zero, others kept.
// (RULE_03) logical shifts move every bit one place and fill the vacated end with zero.
// (RULE_04) rotates pull carry into the vacated end and push the bit shifted out into carry.
// (RULE_05) arithmetic right shift moves bits 7..1 down one place and keeps bit 7.
// (RULE_06) nibble swap exchanges the low and high four bits of the destination at once.
// (RULE_07) status flag set writes one to status bit s and status flag clear writes zero.
// (RULE_08) bit to transfer flag copies source bit b into T; the reverse copies T into bit b.
// (RULE_09) carry, negative and zero flags each have their own set and clear touching only it.
// (RULE_10) global irq enable sets the I flag and global irq disable clears it.
// (RULE_11) sign and overflow flags each have their own set and clear.
// (RULE_12) T has its own set instruction and transfer flag clear clears it.
// (RULE_13) push writes at the stack pointer then decrements; pop increments then reads.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "bsfe_regs.svh"
module bit_shift_flag_execute import bsfe_pkg::*; (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [7:0] awaddr, // axi write address
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte strobes
  output logic bvalid, // axi response valid
  input wire logic bready, // axi response ready
  output logic [1:0] bresp, // axi write response
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  input wire logic [7:0] araddr, // axi read address
  output logic rvalid, // axi read valid
  input wire logic rready, // axi read ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic [7:0] statusOut // status register to the core
);
  logic wrStrobe, wrErr, rdErr;
  logic [7:0] wrAddr, rdAddr;
  logic [31:0] wrData, rdData;
  logic [3:0] wrStrb;

  logic [7:0] work_q [8];
  logic [7:0] io_q [8];
  logic [7:0] stack_q [16];
  logic [7:0] status_q;
  logic [3:0] sp_q;
  logic badOp_q;

  function automatic logic addrOk(logic [7:0] a);
    return (a[1:0] == 2'h0) && ((a <= `ADDR_ERR) ||
      (a >= `ADDR_WORK && a <= `ADDR_WORK_LAST) || (a >= `ADDR_IO && a <= `ADDR_IO_LAST));
  endfunction

  axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // command decode
  wire wrLow = wrStrobe && wrStrb[0] && !wrErr;
  wire cmdWr = wrLow && wrAddr == `ADDR_CMD;
  wire swStatus = wrLow && wrAddr == `ADDR_STATUS;
  wire swSp = wrLow && wrAddr == `ADDR_SP;
  wire swErrClr = wrLow && wrAddr == `ADDR_ERR && wrData[0];
  wire swWork = wrLow && wrAddr[7:5] == 3'h1;
  wire swIo = wrLow && wrAddr[7:5] == 3'h2;
  wire [4:0] opRaw = wrData[`CMD_OP_LSB +: 5];
  wire op_t op = op_t'(opRaw);
  wire legalOp = opRaw <= 5'(OP_T_CLR);
  wire [2:0] dSel = wrData[`CMD_D_LSB +: 3];
  wire [2:0] rSel = wrData[`CMD_R_LSB +: 3];
  wire [2:0] bSel = wrData[`CMD_B_LSB +: 3];
  wire [7:0] dVal = work_q[dSel];
  wire [7:0] rVal = work_q[rSel];
  wire [7:0] ioVal = io_q[dSel];
  wire [3:0] spPlus = sp_q + 4'h1;
  wire [3:0] spMinus = sp_q - 4'h1;

  logic [7:0] shRes;
  logic shCarry;
  shift_unit u_shift (
    .op(op),
    .din(dVal),
    .cin(status_q[`FLAG_C]),
    .dout(shRes),
    .cout(shCarry)
  );

  logic workWe, ioWe, stackWe;
  logic [7:0] workVal, ioVal_d, status_d;
  logic [3:0] sp_d;

  always_comb begin
    workWe = 1'b0;
    ioWe = 1'b0;
    stackWe = 1'b0;
    workVal = dVal;
    ioVal_d = ioVal;
    status_d = status_q;
    sp_d = sp_q;
    if (cmdWr && legalOp) begin
      case (op)
        OP_PUSH: begin
          stackWe = 1'b1; // RULE_01
          sp_d = spMinus; // RULE_13
        end
        OP_POP: begin
          workWe = 1'b1;
          workVal = stack_q[spPlus]; // RULE_01 RULE_13
          sp_d = spPlus; // RULE_13
        end
        OP_IO_BIT_SET: begin
          ioWe = 1'b1;
          ioVal_d = ioVal | bitMask(bSel); // RULE_02
        end
        OP_IO_BIT_CLR: begin
          ioWe = 1'b1;
          ioVal_d = ioVal & ~bitMask(bSel); // RULE_02
        end
        OP_LOG_SHL, OP_LOG_SHR, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ARITH_SHR,
        OP_NIBBLE_SWAP: begin
          workWe = 1'b1;
          workVal = shRes; // RULE_03 RULE_05 RULE_06
          status_d[`FLAG_C] = shCarry; // RULE_04
        end
        OP_STATUS_SET: status_d[bSel] = 1'b1; // RULE_07
        OP_STATUS_CLR: status_d[bSel] = 1'b0; // RULE_07
        OP_BIT_TO_T: status_d[`FLAG_T] = rVal[bSel]; // RULE_08
        OP_T_TO_BIT: begin
          workWe = 1'b1;
          workVal[bSel] = status_q[`FLAG_T]; // RULE_08
        end
        // single-flag instructions share one table
        default: status_d = applyFlag(op, status_q); // RULE_09 RULE_10 RULE_11 RULE_12
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= `STATUS_RESET;
      sp_q <= `SP_RESET;
      badOp_q <= 1'b0;
    end else begin
      status_q <= swStatus ? wrData[7:0] : status_d;
      sp_q <= swSp ? wrData[3:0] : sp_d;
      // a bad command in the clearing write itself cannot happen: one write at a time
      badOp_q <= (cmdWr && !legalOp) || (badOp_q && !swErrClr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        work_q[i] <= `WORK_RESET;
        io_q[i] <= `WORK_RESET;
      end
    end else begin
      if (workWe) begin
        work_q[dSel] <= workVal;
      end else if (swWork) begin
        work_q[wrAddr[4:2]] <= wrData[7:0];
      end
      if (ioWe) begin
        io_q[dSel] <= ioVal_d;
      end else if (swIo) begin
        io_q[wrAddr[4:2]] <= wrData[7:0];
      end
    end
  end

  // stack contents are not reset, as in a plain data memory
  always_ff @(posedge clk) begin
    if (stackWe) begin
      stack_q[sp_q] <= rVal; // RULE_01 RULE_13
    end
  end

  assign statusOut = status_q;
  assign wrErr = !addrOk(wrAddr);
  assign rdErr = !addrOk(rdAddr);

  always_comb begin
    rdData = 32'h0;
    if (rdAddr == `ADDR_STATUS) begin
      rdData = {24'h0, status_q};
    end else if (rdAddr == `ADDR_SP) begin
      rdData = {28'h0, sp_q};
    end else if (rdAddr == `ADDR_ERR) begin
      rdData = {31'h0, badOp_q};
    end else if (rdAddr[7:5] == 3'h1) begin
      rdData = {24'h0, work_q[rdAddr[4:2]]};
    end else if (rdAddr[7:5] == 3'h2) begin
      rdData = {24'h0, io_q[rdAddr[4:2]]};
    end
  end

  // snapshot of each executed command for the checks below
  logic exValid_q;
  op_t exOp_q;
  logic [2:0] exD_q, exB_q;
  logic [7:0] exOld_q, exSrc_q, exIo_q, exStatus_q;
  logic [3:0] exSp_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      exValid_q <= 1'b0;
    end else begin
      exValid_q <= cmdWr && legalOp;
    end
    exOp_q <= op;
    exD_q <= dSel;
    exB_q <= bSel;
    exOld_q <= dVal;
    exSrc_q <= rVal;
    exIo_q <= ioVal;
    exStatus_q <= status_q;
    exSp_q <= sp_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_push_stack: assert property (exValid_q && exOp_q == OP_PUSH |-> // RULE_13
    stack_q[exSp_q] == exSrc_q && sp_q == exSp_q - 4'h1)
    else $error("push did not store at sp then decrement");

  chk_pop_load: assert property (exValid_q && exOp_q == OP_POP |-> // RULE_01
    work_q[exD_q] == stack_q[exSp_q + 4'h1] && sp_q == exSp_q + 4'h1)
    else $error("pop did not increment then load");

  chk_io_bit: assert property (exValid_q && (exOp_q == OP_IO_BIT_SET || // RULE_02
    exOp_q == OP_IO_BIT_CLR) |-> io_q[exD_q] == ((exOp_q == OP_IO_BIT_SET) ?
    (exIo_q | bitMask(exB_q)) : (exIo_q & ~bitMask(exB_q))))
    else $error("io bit operation wrong");

  chk_logic_shift: assert property (exValid_q && exOp_q == OP_LOG_SHL |-> // RULE_03
    work_q[exD_q] == {exOld_q[6:0], 1'b0} && status_q == exStatus_q)
    else $error("logical shift wrong");

  chk_rotate_carry: assert property (exValid_q && exOp_q == OP_ROT_RIGHT |-> // RULE_04
    work_q[exD_q] == {exStatus_q[`FLAG_C], exOld_q[7:1]} && status_q[`FLAG_C] == exOld_q[0])
    else $error("rotate through carry wrong");

  chk_arith_shift: assert property (exValid_q && exOp_q == OP_ARITH_SHR |-> // RULE_05
    work_q[exD_q][7] == exOld_q[7] && work_q[exD_q][6:0] == exOld_q[7:1])
    else $error("arithmetic shift lost the sign");

  chk_nibble_swap: assert property (exValid_q && exOp_q == OP_NIBBLE_SWAP |-> // RULE_06
    work_q[exD_q] == {exOld_q[3:0], exOld_q[7:4]})
    else $error("nibble swap wrong");

  chk_status_bit: assert property (exValid_q && exOp_q == OP_STATUS_SET |-> // RULE_07
    status_q == (exStatus_q | bitMask(exB_q)))
    else $error("status bit set wrong");

  chk_transfer_flag: assert property (exValid_q && exOp_q == OP_T_TO_BIT |-> // RULE_08
    work_q[exD_q][exB_q] == exStatus_q[`FLAG_T] && status_q == exStatus_q)
    else $error("transfer flag to bit wrong");

  chk_single_flag: assert property (exValid_q && exOp_q >= OP_CARRY_SET |-> // RULE_09
    status_q == applyFlag(exOp_q, exStatus_q) && $countones(status_q ^ exStatus_q) <= 1)
    else $error("flag instruction touched more than its flag");

  chk_irq_flag: assert property (exValid_q && exOp_q == OP_IRQ_DIS |-> // RULE_10
    !status_q[`FLAG_I] ##1 (status_q[`FLAG_I] == $past(status_q[`FLAG_I]) || exValid_q
    || swStatus || $past(swStatus)))
    else $error("irq disable did not clear I");

  chk_bad_op: assert property (cmdWr && !legalOp |=> badOp_q && $stable(status_q))
    else $error("illegal command not flagged");

  // commands on the bus are at least a dozen cycles apart
  cov_push_pop: cover property (exValid_q && exOp_q == OP_PUSH ##[1:30]
    exValid_q && exOp_q == OP_POP);
  cov_rotate: cover property (exValid_q && exOp_q == OP_ROT_LEFT && status_q[`FLAG_C]);
  cov_io_set: cover property (exValid_q && exOp_q == OP_IO_BIT_SET);
  cov_bad_op: cover property (cmdWr && !legalOp);
endmodule

/* File: rtl/bsfe_regs.svh */
`ifndef BSFE_REGS_SVH
`define BSFE_REGS_SVH

`define ADDR_CMD 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SP 8'h08
`define ADDR_ERR 8'h0c
`define ADDR_WORK 8'h20
`define ADDR_WORK_LAST 8'h3c
`define ADDR_IO 8'h40
`define ADDR_IO_LAST 8'h5c

`define CMD_OP_LSB 0
`define CMD_D_LSB 8
`define CMD_R_LSB 12
`define CMD_B_LSB 16

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

`define STATUS_RESET 8'h00
`define SP_RESET 4'hf
`define WORK_RESET 8'h00

`endif

/* File: rtl/bsfe_pkg.sv */
`include "bsfe_regs.svh"

package bsfe_pkg;

  typedef enum logic [4:0] {
    OP_PUSH, OP_POP, OP_IO_BIT_SET, OP_IO_BIT_CLR,
    OP_LOG_SHL, OP_LOG_SHR, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ARITH_SHR, OP_NIBBLE_SWAP,
    OP_STATUS_SET, OP_STATUS_CLR, OP_BIT_TO_T, OP_T_TO_BIT,
    OP_CARRY_SET, OP_CARRY_CLR, OP_NEG_SET, OP_NEG_CLR, OP_ZERO_SET, OP_ZERO_CLR,
    OP_IRQ_EN, OP_IRQ_DIS, OP_SIGN_SET, OP_SIGN_CLR, OP_OVF_SET, OP_OVF_CLR,
    OP_T_SET, OP_T_CLR
  } op_t;

  // named single-flag instructions; anything else leaves the status untouched
  function automatic logic [7:0] applyFlag(op_t op, logic [7:0] s);
    logic [7:0] r;
    r = s;
    case (op)
      OP_CARRY_SET: r[`FLAG_C] = 1'b1;
      OP_CARRY_CLR: r[`FLAG_C] = 1'b0;
      OP_NEG_SET: r[`FLAG_N] = 1'b1;
      OP_NEG_CLR: r[`FLAG_N] = 1'b0;
      OP_ZERO_SET: r[`FLAG_Z] = 1'b1;
      OP_ZERO_CLR: r[`FLAG_Z] = 1'b0;
      OP_IRQ_EN: r[`FLAG_I] = 1'b1;
      OP_IRQ_DIS: r[`FLAG_I] = 1'b0;
      OP_SIGN_SET: r[`FLAG_S] = 1'b1;
      OP_SIGN_CLR: r[`FLAG_S] = 1'b0;
      OP_OVF_SET: r[`FLAG_V] = 1'b1;
      OP_OVF_CLR: r[`FLAG_V] = 1'b0;
      OP_T_SET: r[`FLAG_T] = 1'b1;
      OP_T_CLR: r[`FLAG_T] = 1'b0;
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] bitMask(logic [2:0] b);
    return 8'h01 << b;
  endfunction

endpackage

/* File: rtl/shift_unit.sv */
`timescale 1ns/100ps
module shift_unit import bsfe_pkg::*; (
  input wire op_t op, // operation
  input wire logic [7:0] din, // destination value
  input wire logic cin, // carry in
  output logic [7:0] dout, // result
  output logic cout // carry out
);
  always_comb begin
    dout = din;
    cout = cin;
    case (op)
      OP_LOG_SHL: dout = {din[6:0], 1'b0}; // RULE_03
      OP_LOG_SHR: dout = {1'b0, din[7:1]}; // RULE_03
      OP_ROT_LEFT: begin
        dout = {din[6:0], cin}; // RULE_04
        cout = din[7]; // RULE_04
      end
      OP_ROT_RIGHT: begin
        dout = {cin, din[7:1]}; // RULE_04
        cout = din[0]; // RULE_04
      end
      OP_ARITH_SHR: dout = {din[7], din[7:1]}; // RULE_05
      OP_NIBBLE_SWAP: dout = {din[3:0], din[7:4]}; // RULE_06
      default: dout = din;
    endcase
  end
endmodule

/* File: rtl/axil_slave.sv */
`timescale 1ns/100ps
module axil_slave (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  output logic bvalid, // response valid
  input wire logic bready, // response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read address
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic wrStrobe, // register write pulse
  output logic [7:0] wrAddr, // register write address
  output logic [31:0] wrData, // register write data
  output logic [3:0] wrStrb, // register write strobes
  input wire logic wrErr, // address unmapped
  output logic [7:0] rdAddr, // register read address
  input wire logic [31:0] rdData, // register read data
  input wire logic rdErr // address unmapped
);
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;

  // one write in flight; address and data may come in either order
  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wrStrobe = awHeld_q && wHeld_q;
  assign wrAddr = awAddr_q;
  assign wrData = wData_q;
  assign wrStrb = wStrb_q;
  assign rdAddr = araddr;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bresp_q <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (wrStrobe) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrErr ? 2'h2 : 2'h0;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdErr ? 32'h0 : rdData;
      rresp_q <= rdErr ? 2'h2 : 2'h0;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
`include "bsfe_regs.svh"
module tb import bsfe_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] statusOut;
  logic [7:0] wk[8], io[8], stk[16], stat;
  logic [3:0] sp;
  logic [31:0] lfsrQ = 32'h8369;
  logic [31:0] x, v;
  logic [1:0] rs;
  int bad_count = 0, comparisons = 0, cycles = 0;
  int flagPos[7] = '{`FLAG_C, `FLAG_N, `FLAG_Z, `FLAG_I, `FLAG_S, `FLAG_V, `FLAG_T};

  bit_shift_flag_execute u_bit_shift_flag_execute (.clk(clk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .statusOut(statusOut));

  always #2 clk = ~clk;

  // hang guard, far above the ~4k cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  function automatic logic [31:0] nextRand();
    lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
    return lfsrQ;
  endfunction

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // address and data offered together; each released once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
    logic got;
    got = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic got;
    got = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  function automatic void modelStep(input logic [4:0] op, input logic [2:0] d,
                                    input logic [2:0] r, input logic [2:0] b);
    logic [7:0] o;
    o = wk[d];
    case (op)
      OP_PUSH: begin
        stk[sp] = wk[r];
        sp = sp - 4'h1;
      end
      OP_POP: begin
        sp = sp + 4'h1;
        wk[d] = stk[sp];
      end
      OP_IO_BIT_SET: io[d][b] = 1'b1;
      OP_IO_BIT_CLR: io[d][b] = 1'b0;
      OP_LOG_SHL: wk[d] = {o[6:0], 1'b0};
      OP_LOG_SHR: wk[d] = {1'b0, o[7:1]};
      OP_ROT_LEFT: begin
        wk[d] = {o[6:0], stat[`FLAG_C]};
        stat[`FLAG_C] = o[7];
      end
      OP_ROT_RIGHT: begin
        wk[d] = {stat[`FLAG_C], o[7:1]};
        stat[`FLAG_C] = o[0];
      end
      OP_ARITH_SHR: wk[d] = {o[7], o[7:1]};
      OP_NIBBLE_SWAP: wk[d] = {o[3:0], o[7:4]};
      OP_STATUS_SET: stat[b] = 1'b1;
      OP_STATUS_CLR: stat[b] = 1'b0;
      OP_BIT_TO_T: stat[`FLAG_T] = wk[r][b];
      OP_T_TO_BIT: wk[d][b] = stat[`FLAG_T];
      default: begin
        // even codes set, odd codes clear the named flag
        if (op >= 5'h0e && op <= 5'h1b) begin
          stat[flagPos[(op - 5'h0e) >> 1]] = ~op[0];
        end
      end
    endcase
  endfunction

  task automatic runOp(input logic [4:0] op, input logic [2:0] d, input logic [2:0] r,
                       input logic [2:0] b);
    logic [31:0] rv, so;
    logic [1:0] rsp;
    axiWrite(`ADDR_CMD, {13'h0, b, 1'b0, r, 1'b0, d, 3'h0, op}, 4'hf, rsp);
    modelStep(op, d, r, b);
    so = {24'h0, statusOut};
    check({30'h0, rsp}, 32'h0, "command response");
    check(so, {24'h0, stat}, "status");
    axiRead(`ADDR_WORK + {3'h0, d, 2'b00}, rv, rsp);
    check(rv, {24'h0, wk[d]}, "work reg");
    axiRead(`ADDR_IO + {3'h0, d, 2'b00}, rv, rsp);
    check(rv, {24'h0, io[d]}, "io reg");
    axiRead(`ADDR_SP, rv, rsp);
    check(rv, {28'h0, sp}, "stack pointer");
  endtask

  initial begin
    stat = `STATUS_RESET;
    sp = `SP_RESET;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      axiRead(`ADDR_WORK + 8'(4 * i), v, rs);
      check(v, 32'h0, "work reset");
      axiRead(`ADDR_IO + 8'(4 * i), v, rs);
      check(v, 32'h0, "io reset");
      x = nextRand();
      wk[i] = x[7:0];
      io[i] = x[15:8];
      axiWrite(`ADDR_WORK + 8'(4 * i), {24'h0, wk[i]}, 4'hf, rs);
      axiWrite(`ADDR_IO + 8'(4 * i), {24'h0, io[i]}, 4'hf, rs);
    end
    axiRead(`ADDR_SP, v, rs);
    check(v, 32'h0000000f, "sp reset");
    check({24'h0, statusOut}, 32'h0, "status reset");
    x = nextRand();
    stat = x[7:0];
    axiWrite(`ADDR_STATUS, {24'h0, stat}, 4'hf, rs);
    axiRead(8'h10, v, rs);
    check({v[31:2], rs}, 32'h2, "unmapped read");
    axiWrite(8'h14, 32'h0, 4'hf, rs);
    check({30'h0, rs}, 32'h2, "unmapped write");
    // strobe 0 must leave the register alone
    axiWrite(`ADDR_WORK, 32'h000000a5, 4'h0, rs);
    axiRead(`ADDR_WORK, v, rs);
    check(v, {24'h0, wk[0]}, "masked write");
    // fill the whole stack first so later pops never see unwritten entries
    repeat (16) begin
      x = nextRand();
      runOp(5'd0, x[2:0], x[5:3], x[8:6]);
    end
    // software moves the stack pointer; every entry is written, so any value is safe
    x = nextRand();
    sp = x[3:0];
    axiWrite(`ADDR_SP, {28'h0, sp}, 4'hf, rs);
    axiRead(`ADDR_SP, v, rs);
    check(v, {28'h0, sp}, "sp write");
    for (int op = 1; op < 28; op++) begin
      x = nextRand();
      runOp(5'(op), x[2:0], x[5:3], x[8:6]);
    end
    repeat (250) begin
      x = nextRand();
      runOp(5'(x[15:8] % 28), x[2:0], x[5:3], x[18:16]);
    end
    for (int op = 28; op < 32; op++) begin
      runOp(5'(op), 3'h1, 3'h2, 3'h3);
      axiRead(`ADDR_ERR, v, rs);
      check(v, 32'h1, "error set");
      axiWrite(`ADDR_ERR, 32'h1, 4'hf, rs);
      axiRead(`ADDR_ERR, v, rs);
      check(v, 32'h0, "error cleared");
    end
    conclude();
  end
endmodule
